// ### pfr_fault_response.sv
/*
 * Overcurrent and internal overtemperature fault response for a
 * two-channel power controller, with its response bytes and status.
 * Assumes a command decoder that presents byte reads and writes as
 * one-cycle strobes, and run inputs already combining the run pin
 * with the operation command.
 */
// Overview of operation
// - overcurrent sets status bits and alert
// - response 00 limits current forever
// - response 10 limits then applies retry
// - response 11 shuts down then applies retry
// - no-retry holds off until run cycled
// - continuous retry spaced by retry interval
// - delay field counts 16ms, deglitch only
// - overcurrent bit clears on listed events
// - overtemp response read only, default c0
// - overtemp sets status bits and alert
// - overtemp response 00/01 raises cml
// - overtemp response 10 disables immediately
// - overtemp response 11 resumes when clear
// - overtemp retry nonzero raises cml
// - overtemp delay field ignored
// - overtemp bit clears on listed events
// - overcurrent response 0x47, paged, default 00
`timescale 1ns/1ps
module pfr_fault_response #(
    parameter int MS_CYCLES = pfr_pkg::MS_CYCLES
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_page,
    input wire logic [7:0] cmd_wdata,
    output logic [7:0] cmd_rdata,
    output logic cmd_rvalid,
    input wire logic clear_faults,
    input wire logic restore_user_all,
    input wire logic device_soft_reset_command,
    input wire logic [1:0] run_on,
    input wire logic [1:0] oc_detect,
    input wire logic ot_detect,
    input wire logic [7:0] restart_interval_setting,
    input wire logic alert_mask,
    output logic [1:0] out_en,
    output logic [1:0] ilim_en,
    output logic [1:0] status_iout_oc,
    output logic status_mfr_ot,
    output logic status_cml,
    output logic [1:0][7:0] status_byte,
    output logic [1:0][7:0] status_word_hi,
    output logic alert_n
);
    import pfr_pkg::*;

    localparam int PW = $clog2(MS_CYCLES);

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    logic [PW-1:0] pre;
    logic tick;
    logic [7:0] oc_resp [2];
    logic [7:0] ot_resp;
    pfr_state_e state [2];
    pfr_state_e next_state [2];
    logic [TMR_W-1:0] tmr [2];
    logic [TMR_W-1:0] next_tmr [2];
    logic [1:0] run_q;
    logic [1:0] run_rise;
    logic [1:0] next_ilim;
    logic [1:0] oc_set;
    logic oc_wr_bad;
    logic ot_wr_bad;
    logic flag_clr;
    logic [1:0] next_oc;
    logic next_ot;
    logic next_cml;

    // ---------------------------------------------------------------
    // millisecond tick
    // ---------------------------------------------------------------
    assign tick = pre == PW'(MS_CYCLES - 1);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pre <= '0;
        end else if (tick) begin
            pre <= '0;
        end else begin
            pre <= pre + PW'(1);
        end
    end

    // ---------------------------------------------------------------
    // response byte access
    // ---------------------------------------------------------------
    assign oc_wr_bad = cmd_wr && cmd_code == CMD_OC_RESP
        && cmd_wdata[RESP_HI:RESP_LO] == RSP_BAD;
    // response byte is read only; bad values still flag
    assign ot_wr_bad = cmd_wr && cmd_code == CMD_OT_RESP
        && (cmd_wdata[RESP_HI:RESP_LO] < OT_RSP_LATCH
        || cmd_wdata[RETRY_HI:RETRY_LO] != RETRY_NONE);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            oc_resp[0] <= OC_RESP_RST;
            oc_resp[1] <= OC_RESP_RST;
        end else if (cmd_wr && cmd_code == CMD_OC_RESP && !oc_wr_bad) begin
            oc_resp[cmd_page] <= cmd_wdata;
        end
    end

    // unpaged, never written
    assign ot_resp = OT_RESP_RST;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmd_rdata <= RD_UNMAPPED;
            cmd_rvalid <= 1'b0;
        end else begin
            cmd_rvalid <= cmd_rd;
            if (cmd_rd) begin
                if (cmd_code == CMD_OC_RESP) begin
                    cmd_rdata <= oc_resp[cmd_page];
                end else if (cmd_code == CMD_OT_RESP) begin
                    cmd_rdata <= ot_resp;
                end else begin
                    cmd_rdata <= RD_UNMAPPED;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // channel sequencing
    // ---------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            next_state[c] = state[c];
            next_tmr[c] = tmr[c];
            next_ilim[c] = 1'b0;
            if (tick && tmr[c] != '0) begin
                next_tmr[c] = tmr[c] - TMR_W'(1);
            end
            unique case (state[c])
                ST_OFF: begin
                    // no start while overtemp persists
                    if (run_on[c] && !ot_detect) begin
                        next_state[c] = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (ot_detect) begin
                        next_state[c] = ST_OT;
                    end else if (oc_detect[c]) begin
                        unique case (oc_resp[c][RESP_HI:RESP_LO])
                            RSP_DEGLITCH: begin
                                next_state[c] = ST_LIMIT;
                                next_tmr[c] =
                                    pfr_oc_delay(oc_resp[c]);
                                next_ilim[c] = 1'b1;
                            end
                            RSP_SHUT: begin
                                if (pfr_retry_cont(oc_resp[c])) begin
                                    next_state[c] = ST_RETRY;
                                    next_tmr[c] = TMR_W'(
                                        restart_interval_setting);
                                end else begin
                                    next_state[c] = ST_LATCH;
                                end
                            end
                            default: begin
                                next_ilim[c] = 1'b1;
                            end
                        endcase
                    end
                end
                ST_LIMIT: begin
                    if (ot_detect) begin
                        next_state[c] = ST_OT;
                    end else if (!oc_detect[c]) begin
                        next_state[c] = ST_RUN;
                    end else if (tmr[c] == '0) begin
                        if (pfr_retry_cont(oc_resp[c])) begin
                            next_state[c] = ST_RETRY;
                            next_tmr[c] = TMR_W'(
                                restart_interval_setting);
                        end else begin
                            next_state[c] = ST_LATCH;
                        end
                    end else begin
                        next_ilim[c] = 1'b1;
                    end
                end
                ST_RETRY: begin
                    if (ot_detect) begin
                        next_state[c] = ST_OT;
                    end else if (tmr[c] == '0) begin
                        next_state[c] = ST_RUN;
                    end
                end
                ST_LATCH: begin
                    next_state[c] = ST_LATCH;
                end
                ST_OT: begin
                    // delay field never consulted
                    if (ot_resp[RESP_HI:RESP_LO] == OT_RSP_HYST) begin
                        if (!ot_detect) begin
                            next_state[c] = ST_RUN;
                        end
                    end else if (clear_faults && !ot_detect) begin
                        next_state[c] = ST_OFF;
                    end
                end
            endcase
            if (!run_on[c]) begin
                next_state[c] = ST_OFF;
                next_ilim[c] = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int c = 0; c < 2; c++) begin
                state[c] <= ST_OFF;
                tmr[c] <= '0;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                state[c] <= next_state[c];
                tmr[c] <= next_tmr[c];
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            out_en <= 2'h0;
            ilim_en <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                out_en[c] <= next_state[c] == ST_RUN
                    || next_state[c] == ST_LIMIT;
                ilim_en[c] <= next_ilim[c];
            end
        end
    end

    // ---------------------------------------------------------------
    // latched fault flags
    // ---------------------------------------------------------------
    assign run_rise = run_on & ~run_q;
    assign flag_clr = clear_faults || restore_user_all
        || device_soft_reset_command;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            run_q <= 2'h0;
        end else begin
            run_q <= run_on;
        end
    end

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            oc_set[c] = oc_detect[c]
                && (state[c] == ST_RUN || state[c] == ST_LIMIT);
            // set wins over clear
            next_oc[c] = oc_set[c] || (status_iout_oc[c]
                && !(flag_clr || run_rise[c]));
        end
        next_ot = ot_detect || (status_mfr_ot
            && !(clear_faults || |run_rise));
        next_cml = oc_wr_bad || ot_wr_bad
            || (status_cml && !flag_clr);
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            status_iout_oc <= 2'h0;
            status_mfr_ot <= 1'b0;
            status_cml <= 1'b0;
        end else begin
            status_iout_oc <= next_oc;
            status_mfr_ot <= next_ot;
            status_cml <= next_cml;
        end
    end

    // ---------------------------------------------------------------
    // status bytes and alert
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            status_byte <= '0;
            status_word_hi <= '0;
            alert_n <= 1'b1;
        end else begin
            for (int c = 0; c < 2; c++) begin
                status_byte[c] <= '0;
                status_word_hi[c] <= '0;
                status_byte[c][SB_NONE] <=
                    next_oc[c] || next_ot;
                status_byte[c][SB_IOUT_OC] <= next_oc[c];
                status_byte[c][SB_CML] <= next_cml;
                status_word_hi[c][SW_IOUT] <= next_oc[c];
                status_word_hi[c][SW_MFR] <= next_ot;
            end
            alert_n <= !((|next_oc || next_ot || next_cml)
                && !alert_mask);
        end
    end
endmodule

// ### pfr_pkg.sv
/*
 * Constants, types and helpers for the overcurrent and internal
 * overtemperature fault-response block.
 * Assumes a single 100 MHz device clock.
 */
package pfr_pkg;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_MS = 1;
    localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int OC_DELAY_UNIT_MS = 16;
    localparam int TMR_W = 12;

    // ---------------------------------------------------------------
    // command codes and reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] CMD_OC_RESP = 8'h47;
    localparam logic [7:0] CMD_OT_RESP = 8'hd6;
    localparam logic [7:0] OC_RESP_RST = 8'h00;
    localparam logic [7:0] OT_RESP_RST = 8'hc0;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // ---------------------------------------------------------------
    // response byte fields
    // ---------------------------------------------------------------
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DLY_HI = 2;
    localparam int DLY_LO = 0;
    localparam logic [1:0] RSP_LIMIT = 2'h0;
    localparam logic [1:0] RSP_BAD = 2'h1;
    localparam logic [1:0] RSP_DEGLITCH = 2'h2;
    localparam logic [1:0] RSP_SHUT = 2'h3;
    localparam logic [1:0] OT_RSP_LATCH = 2'h2;
    localparam logic [1:0] OT_RSP_HYST = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;

    // ---------------------------------------------------------------
    // status bit positions
    // ---------------------------------------------------------------
    localparam int SB_NONE = 0;
    localparam int SB_CML = 1;
    localparam int SB_IOUT_OC = 4;
    localparam int SW_IOUT = 6;
    localparam int SW_MFR = 4;

    typedef enum logic [2:0] {
        ST_OFF, ST_RUN, ST_LIMIT, ST_RETRY, ST_LATCH, ST_OT
    } pfr_state_e;

    function automatic logic pfr_retry_cont(input logic [7:0] r);
        return r[RETRY_HI:RETRY_LO] != RETRY_NONE;
    endfunction

    function automatic logic [TMR_W-1:0] pfr_oc_delay(
        input logic [7:0] r);
        return TMR_W'(r[DLY_HI:DLY_LO]) * TMR_W'(OC_DELAY_UNIT_MS);
    endfunction
endpackage

// ### pfr_fault_response_asserts.sv
/* Port checks for the fault-response block.
   Assumes one clock mclk and async active-low nrst. */
`timescale 1ns/1ps
module pfr_fault_response_asserts #(
    parameter int MS_CYCLES = 10
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_wdata,
    input wire logic [7:0] cmd_rdata,
    input wire logic cmd_rvalid,
    input wire logic [1:0] run_on,
    input wire logic [1:0] oc_detect,
    input wire logic ot_detect,
    input wire logic alert_mask,
    input wire logic [1:0] out_en,
    input wire logic [1:0] status_iout_oc,
    input wire logic status_mfr_ot,
    input wire logic status_cml,
    input wire logic [1:0][7:0] status_byte,
    input wire logic [1:0][7:0] status_word_hi,
    input wire logic alert_n
);
    // ----------------
    // properties
    // ----------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    sequence s_rd_ot;
        cmd_rd && cmd_code == 8'hd6;
    endsequence
    sequence s_bad_ot;
        cmd_wr && cmd_code == 8'hd6 && (!cmd_wdata[7] || cmd_wdata[5:3] != 0);
    endsequence
    a_ot_rd_value: assert property (
        s_rd_ot |=> cmd_rvalid && cmd_rdata == 8'hc0)
        else $error("ot response read wrong");
    a_bad_ot_cml: assert property (
        s_bad_ot |=> status_cml)
        else $error("bad ot write gave no cml");
    a_oc_flag_set: assert property (
        out_en[0] && run_on[0] && oc_detect[0] |=> status_iout_oc[0])
        else $error("oc flag not set");
    a_oc_status: assert property (
        status_iout_oc[0] |-> status_byte[0][4] && status_byte[0][0]
        && status_word_hi[0][6]) else $error("oc status bits missing");
    a_alert_on: assert property (
        (|status_iout_oc || status_mfr_ot || status_cml)
        && !$past(alert_mask) |-> !alert_n) else $error("alert missing");
    a_ot_status: assert property (
        status_mfr_ot |-> status_word_hi[0][4] && status_word_hi[1][4]
        && status_byte[1][0]) else $error("ot status bits missing");
    a_ot_off: assert property (
        ot_detect |=> out_en == 2'h0) else $error("output on in ot");
    a_run_low_off: assert property (
        !run_on[0] |=> !out_en[0]) else $error("output on without run");
endmodule
bind pfr_fault_response pfr_fault_response_asserts #(
    .MS_CYCLES(MS_CYCLES)
) i_pfr_fault_response_asserts (
    .mclk, .nrst, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata,
    .cmd_rdata, .cmd_rvalid, .run_on, .oc_detect, .ot_detect,
    .alert_mask, .out_en, .status_iout_oc, .status_mfr_ot,
    .status_cml, .status_byte, .status_word_hi, .alert_n
);

// ### pfr_host.sv
/* Host model driving the command port one byte at a time.
   Assumes strobes are taken on the rising mclk edge. */
`timescale 1ns/1ps
module pfr_host (
    output logic cmd_wr = 0,
    output logic cmd_rd = 0,
    output logic [7:0] cmd_code = 8'h00,
    output logic cmd_page = 0,
    output logic [7:0] cmd_wdata = 8'h00,
    input wire logic mclk,
    input wire logic [7:0] cmd_rdata,
    input wire logic cmd_rvalid
);
    // one strobe, then qualifiers scrambled while idle
    task automatic go(input logic w, input logic [7:0] c, input logic p,
                      input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk);
        #1;
        cmd_wr = w;
        cmd_rd = !w;
        cmd_code = c;
        cmd_page = p;
        cmd_wdata = d;
        @(posedge mclk);
        #1;
        cmd_wr = 0;
        cmd_rd = 0;
        cmd_code = ~c;
        cmd_page = !p;
        cmd_wdata = ~d;
        q = (cmd_rvalid === 1'b1) ? cmd_rdata : 8'hxx;
    endtask
endmodule

// ### tb_pfr_fault_response.sv
/* Testbench for the fault-response block with a host model.
   Assumes MS_CYCLES of 10, so one ms tick is ten clocks. */
`timescale 1ns/1ps
module tb_pfr_fault_response;
    logic mclk = 0;
    logic nrst = 0;
    logic [2:0] ev = 3'h0;
    logic [1:0] run_on = 2'h0;
    logic [1:0] oc_detect = 2'h0;
    logic ot_detect = 0;
    logic alert_mask = 0;
    logic cmd_wr, cmd_rd, cmd_page, cmd_rvalid, status_mfr_ot, status_cml;
    logic alert_n;
    logic [7:0] cmd_code, cmd_wdata, cmd_rdata, v;
    logic [1:0] out_en, ilim_en, status_iout_oc;
    logic [1:0][7:0] status_byte, status_word_hi;
    int n_errors = 0;
    int cmp_count = 0;
    always #5 mclk = ~mclk;
    pfr_host i_pfr_host (.mclk, .cmd_wr, .cmd_rd, .cmd_code, .cmd_page,
        .cmd_wdata, .cmd_rdata, .cmd_rvalid);
    pfr_fault_response #(.MS_CYCLES(10)) i_pfr_fault_response (
        .mclk, .nrst, .cmd_wr, .cmd_rd, .cmd_code, .cmd_page, .cmd_wdata,
        .cmd_rdata, .cmd_rvalid, .clear_faults(ev[0]),
        .restore_user_all(ev[1]), .device_soft_reset_command(ev[2]),
        .run_on, .oc_detect, .ot_detect, .restart_interval_setting(8'h04),
        .alert_mask, .out_en, .ilim_en, .status_iout_oc, .status_mfr_ot,
        .status_cml, .status_byte, .status_word_hi, .alert_n);
    // ----------------
    // helpers
    // ----------------
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string s, input logic [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic p, input logic [7:0] d);
        i_pfr_host.go(1, c, p, d, v);
    endtask
    task automatic rchk(input logic [7:0] c, input logic p,
                        input logic [7:0] e);
        i_pfr_host.go(0, c, p, 8'h00, v);
        chk("rdata", e, v);
    endtask
    task automatic pulse(input int i);
        ev[i] = 1;
        cyc(1);
        ev = 3'h0;
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_regs;
        logic [7:0] bad [4] = '{8'h00, 8'h7f, 8'h88, 8'hb8};
        chk("alert_n", 1, alert_n);
        rchk(8'h47, 0, 8'h00);
        rchk(8'hd6, 0, 8'hc0);
        rchk(8'h5a, 0, 8'h00);
        wr(8'h47, 1, 8'h98);
        rchk(8'h47, 1, 8'h98);
        rchk(8'h47, 0, 8'h00);
        wr(8'h47, 1, 8'h40);
        chk("cml", 1, status_cml);
        rchk(8'h47, 1, 8'h98);
        foreach (bad[i]) begin
            pulse(0);
            chk("cml", 0, status_cml);
            wr(8'hd6, 0, bad[i]);
            chk("cml", 1, status_cml);
        end
        pulse(0);
        wr(8'hd6, 0, 8'hc7);
        chk("cml", 0, status_cml);
        rchk(8'hd6, 0, 8'hc0);
    endtask
    task automatic t_limit;
        run_on = 2'h3;
        oc_detect = 2'h1;
        cyc(300);
        chk("out_en", 3, out_en);
        chk("ilim_en", 1, ilim_en);
        chk("sbyte", 8'h11, status_byte[0]);
        chk("sword", 8'h40, status_word_hi[0]);
        alert_mask = 1;
        cyc(2);
        chk("alert_n", 1, alert_n);
        alert_mask = 0;
        for (int i = 0; i < 3; i++) begin
            oc_detect = 2'h0;
            cyc(50);
            chk("oc_flag", 1, status_iout_oc[0]);
            pulse(i);
            chk("oc_flag", 0, status_iout_oc[0]);
            oc_detect = 2'h1;
            cyc(3);
        end
        oc_detect = 2'h0;
        pulse(0);
    endtask
    task automatic t_delay;
        wr(8'h47, 0, 8'h81);
        oc_detect = 2'h1;
        cyc(140);
        chk("out_en0", 1, out_en[0]);
        cyc(40);
        chk("out_en0", 0, out_en[0]);
        oc_detect = 2'h0;
        cyc(300);
        chk("out_en0", 0, out_en[0]);
        run_on = 2'h2;
        cyc(3);
        run_on = 2'h3;
        cyc(5);
        chk("out_en0", 1, out_en[0]);
        chk("oc_flag", 0, status_iout_oc[0]);
    endtask
    task automatic t_retry;
        wr(8'h47, 0, 8'hcf);
        repeat (2) begin
            oc_detect = 2'h1;
            cyc(2);
            oc_detect = 2'h0;
            chk("out_en0", 0, out_en[0]);
            cyc(25);
            chk("out_en0", 0, out_en[0]);
            cyc(30);
            chk("out_en0", 1, out_en[0]);
        end
        wr(8'h47, 0, 8'h00);
        pulse(0);
    endtask
    task automatic t_ot;
        ot_detect = 1;
        cyc(50);
        chk("out_en", 0, out_en);
        chk("sword1", 8'h10, status_word_hi[1]);
        chk("sbyte1", 8'h01, status_byte[1]);
        chk("alert_n", 0, alert_n);
        run_on = 2'h2;
        cyc(2);
        run_on = 2'h3;
        cyc(3);
        chk("out_en", 0, out_en);
        ot_detect = 0;
        cyc(10);
        chk("out_en", 3, out_en);
        chk("ot_flag", 1, status_mfr_ot);
        pulse(0);
        chk("ot_flag", 0, status_mfr_ot);
    endtask
    initial begin
        cyc(10);
        nrst = 1;
        t_regs();
        t_limit();
        t_delay();
        t_retry();
        t_ot();
        report_and_stop();
    end
    initial begin
        #100000;
        n_errors++;
        report_and_stop();
    end
endmodule
